// ===== logic/tmc_pkg.sv
// package: offsets, reset values, thresholds and carriers of the tx statistics counters
`default_nettype none

package tmc_pkg;

  // counter geometry
  localparam int          CNT_W          = 32;
  localparam int          NUM_CNT        = 2;
  localparam int          ADDR_W         = 8;
  localparam int          OCTET_W        = 16;
  localparam int          COLL_W         = 5;

  // counter slots in the bank
  localparam int          IDX_TX_OCTET   = 0;
  localparam int          IDX_SINGLE_COL = 1;

  // register offsets inside the io and memory windows, index by counter slot
  localparam logic [ADDR_W-1:0] OFS_TX_OCTET   = 8'hEC;
  localparam logic [ADDR_W-1:0] OFS_SINGLE_COL = 8'hF0;
  localparam logic [NUM_CNT-1:0][ADDR_W-1:0] CNT_OFS = {OFS_SINGLE_COL, OFS_TX_OCTET};

  // values after reset and at the update mark
  localparam logic [CNT_W-1:0]  CNT_RESET      = 32'h0000_0000;
  localparam logic [CNT_W-1:0]  CNT_THRESH     = 32'hC000_0000;
  localparam logic [CNT_W-1:0]  CNT_ONE        = 32'h0000_0001;
  localparam logic [CNT_W-1:0]  VLAN_TAG_OCTETS = 32'h0000_0004;
  localparam logic [COLL_W-1:0] COLL_ONE       = 5'h01;
  localparam logic [3:0]        BE_DWORD       = 4'hF;
  localparam logic [CNT_W-1:0]  RDATA_UNMAPPED = 32'h0000_0000;

  // end-of-frame report from the mac transmit path
  typedef struct packed {
    logic               done;          // one-cycle pulse, frame left the mac
    logic               ok;            // frame transmitted successfully
    logic [OCTET_W-1:0] octets;        // data plus padding octets, tag excluded
    logic               vlan_inserted; // mac added a tag to this frame
    logic [COLL_W-1:0]  collisions;    // collisions met before success
  } tmc_tx_event_type;

  // register access from the window decoder
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [3:0]        be;
    logic [CNT_W-1:0]  wdata;
  } tmc_reg_req_type;

  typedef struct packed {
    logic             ack;
    logic             err;
    logic [CNT_W-1:0] rdata;
  } tmc_reg_rsp_type;

endpackage : tmc_pkg

`default_nettype wire

// ===== logic/tmc_stat_counter.sv
// module: one wrapping statistics counter with update-mark detection
`default_nettype none

module tmc_stat_counter
  import tmc_pkg::*;
#(
  parameter int             W      = 32,
  parameter logic [W-1:0]   THRESH = 32'hC000_0000
)(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic         sw_clear,
  // counting
  input  wire logic         enable,
  input  wire logic         inc_valid,
  input  wire logic [W-1:0] inc_amount,
  // software write
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  // state
  output logic [W-1:0]      count_q,
  output logic              mark_hit
);

  logic [W-1:0] count_d;
  logic [W:0]   sum;
  logic         counting;

  ////////////////////////////////////////////////////////////////////////////
  // next count: clear, then software write, then increment
  always_comb begin
    counting = enable && inc_valid;                        // [R05] [R09] [R11]
    sum      = {1'b0, count_q} + {1'b0, inc_amount};
    count_d  = count_q;                                    // hold when idle [R11]
    mark_hit = 1'b0;
    if (sw_clear) begin
      count_d = CNT_RESET[W-1:0];
    end else if (wr_en) begin
      count_d = wr_data;
    end else if (counting) begin
      count_d  = sum[W-1:0];                               // carry dropped [R02] [R07]
      // octet steps can jump over the exact mark, so detect the crossing
      mark_hit = (count_q < THRESH) && (sum[W-1:0] >= THRESH) && !sum[W]; // [R04] [R08]
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count_q <= CNT_RESET[W-1:0];                         // [R10]
    end else begin
      count_q <= count_d;
    end
  end

endmodule : tmc_stat_counter

`default_nettype wire

// ===== logic/tmc_tx_event_qual.sv
// module: turns a mac end-of-frame report into counter increments
`default_nettype none

module tmc_tx_event_qual
  import tmc_pkg::*;
(
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rstn,
  // frame report
  input  wire tmc_pkg::tmc_tx_event_type tx_evt,
  // increments, registered
  output logic                         octet_vld_q,
  output logic [tmc_pkg::CNT_W-1:0]    octet_inc_q,
  output logic                         single_col_q
);

  logic                 octet_vld_d;
  logic [CNT_W-1:0]     octet_inc_d;
  logic                 single_col_d;
  logic                 good_frame;

  ////////////////////////////////////////////////////////////////////////////
  // qualify the report; the tag is added back so byte counts see the wire
  always_comb begin
    good_frame   = tx_evt.done && tx_evt.ok;
    octet_vld_d  = good_frame;                                       // [R01]
    octet_inc_d  = {{(CNT_W-OCTET_W){1'b0}}, tx_evt.octets};         // [R01]
    if (tx_evt.vlan_inserted) begin
      octet_inc_d = octet_inc_d + VLAN_TAG_OCTETS;                   // [R03]
    end
    single_col_d = good_frame && (tx_evt.collisions == COLL_ONE);    // [R06]
  end

  // one flop stage keeps the adder away from the counter carry chain
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      octet_vld_q  <= 1'b0;
      octet_inc_q  <= CNT_RESET;
      single_col_q <= 1'b0;
    end else begin
      octet_vld_q  <= octet_vld_d;
      octet_inc_q  <= octet_inc_d;
      single_col_q <= single_col_d;
    end
  end

endmodule : tmc_tx_event_qual

`default_nettype wire

// ===== logic/tmc_tx_mib_counters.sv
// module: transmit-side mib counter bank, octets ok and single-collision frames
//
// How it works
// R01: the octet counter adds data and padding octets of each successfully sent frame.
// R02: the octet counter wraps from all ones to zero and keeps counting.
// R03: byte counts include the four tag octets when the mac inserted a tag.
// R04: the octet counter crossing 0xC0000000 raises the statistics update flag.
// R05: the octet counter counts only with global enable one and its mask bit zero.
// R06: the single-collision counter adds one per frame sent ok after exactly one collision.
// R07: the single-collision counter wraps from all ones to zero and keeps counting.
// R08: the single-collision counter crossing 0xC0000000 raises the update flag.
// R09: the single-collision counter counts only with global enable one and mask bit zero.
// R10: the single-collision counter sits at 0xF0, resets to zero, dword access only.
// R11: a disabled or masked counter holds its value and raises no update.
`default_nettype none

module tmc_tx_mib_counters
  import tmc_pkg::*;
#(
  parameter int                       NUM    = tmc_pkg::NUM_CNT,
  parameter logic [tmc_pkg::CNT_W-1:0] THRESH = tmc_pkg::CNT_THRESH
)(
  // clock and resets
  input  wire logic                     clock,
  input  wire logic                     rstn,
  input  wire logic                     sw_reset,
  // mac transmit path report
  input  wire tmc_pkg::tmc_tx_event_type tx_evt,
  // statistics control from mac control and mask registers
  input  wire logic                     stats_global_enable,
  input  wire logic [NUM-1:0]           stats_counter_mask,
  // register window access
  input  wire tmc_pkg::tmc_reg_req_type reg_req,
  output tmc_pkg::tmc_reg_rsp_type      reg_rsp,
  // set pulse toward the interrupt status register
  output logic                          stats_update_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  // increments from the frame report
  logic                  octet_vld;
  logic [CNT_W-1:0]      octet_inc;
  logic                  single_col;

  // per-counter wiring
  logic [NUM-1:0]              cnt_enable;
  logic [NUM-1:0]              cnt_inc_valid;
  logic [NUM-1:0][CNT_W-1:0]   cnt_inc_amount;
  logic [NUM-1:0]              cnt_wr_en;
  logic [NUM-1:0][CNT_W-1:0]   cnt_value;
  logic [NUM-1:0]              cnt_mark_hit;

  // register access decode
  logic [NUM-1:0]        addr_hit;
  logic                  any_hit;
  logic                  access;
  logic                  full_dword;
  logic                  wr_ok;
  logic                  bad_access;
  logic [CNT_W-1:0]      rd_mux;

  // response and update flag state
  logic                  ack_d;
  logic                  ack_q;
  logic                  err_d;
  logic                  err_q;
  logic [CNT_W-1:0]      rdata_d;
  logic [CNT_W-1:0]      rdata_q;
  logic                  irq_d;
  logic                  irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // frame report qualification

  tmc_tx_event_qual u_event_qual (
    .clock        (clock),
    .rstn         (rstn),
    .tx_evt       (tx_evt),
    .octet_vld_q  (octet_vld),
    .octet_inc_q  (octet_inc),
    .single_col_q (single_col)
  );

  ////////////////////////////////////////////////////////////////////////////
  // route increments to the counter slots

  // octets of a good frame go to slot 0, tag octets already included
  always_comb begin
    cnt_inc_valid                  = '0;
    cnt_inc_amount                 = '0;
    cnt_inc_valid[IDX_TX_OCTET]    = octet_vld;                      // [R01]
    cnt_inc_amount[IDX_TX_OCTET]   = octet_inc;                      // [R01] [R03]
    cnt_inc_valid[IDX_SINGLE_COL]  = single_col;                     // [R06]
    cnt_inc_amount[IDX_SINGLE_COL] = CNT_ONE;                        // [R06]
  end

  ////////////////////////////////////////////////////////////////////////////
  // register window decode

  // both counters answer only to full double-word accesses
  always_comb begin
    access     = reg_req.rd || reg_req.wr;
    full_dword = (reg_req.be == BE_DWORD);                           // [R10]
    addr_hit   = '0;
    for (int i = 0; i < NUM; i++) begin
      addr_hit[i] = (reg_req.addr == CNT_OFS[i]);                    // [R10]
    end
    any_hit    = |addr_hit;
    wr_ok      = reg_req.wr && full_dword;
    // unmapped or partial accesses are flagged, never half-applied
    bad_access = access && (!any_hit || !full_dword);
  end

  // read mux, unmapped addresses read as zero
  always_comb begin
    rd_mux = RDATA_UNMAPPED;
    for (int i = 0; i < NUM; i++) begin
      if (addr_hit[i]) begin
        rd_mux = cnt_value[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter slots

  generate
    for (genvar g = 0; g < NUM; g++) begin : g_cnt
      // a masked slot or a cleared global enable freezes the count
      assign cnt_enable[g] = stats_global_enable && !stats_counter_mask[g]; // [R05] [R09]
      assign cnt_wr_en[g]  = wr_ok && addr_hit[g];                   // [R10]

      tmc_stat_counter #(
        .W      (CNT_W),
        .THRESH (THRESH)
      ) u_cnt (
        .clock      (clock),
        .rstn       (rstn),
        .sw_clear   (sw_reset),
        .enable     (cnt_enable[g]),
        .inc_valid  (cnt_inc_valid[g]),
        .inc_amount (cnt_inc_amount[g]),
        .wr_en      (cnt_wr_en[g]),
        .wr_data    (reg_req.wdata),
        .count_q    (cnt_value[g]),
        .mark_hit   (cnt_mark_hit[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // statistics update pulse

  // any slot crossing the mark sets the shared update bit; the status
  // register outside holds it sticky, so a one-cycle pulse is enough
  always_comb begin
    irq_d = |(cnt_mark_hit & cnt_enable);                  // [R04] [R08] [R11]
    if (sw_reset) begin
      irq_d = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register response

  // one-cycle answer to every access; read data is the value before a
  // same-cycle increment lands, which software sees as an ordinary race
  always_comb begin
    ack_d   = access;
    err_d   = bad_access;
    rdata_d = rdata_q;
    if (reg_req.rd) begin
      rdata_d = full_dword ? rd_mux : RDATA_UNMAPPED;                // [R10]
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= CNT_RESET;
    end else begin
      ack_q   <= ack_d;
      err_q   <= err_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rsp.ack      = ack_q;
  assign reg_rsp.err      = err_q;
  assign reg_rsp.rdata    = rdata_q;
  assign stats_update_irq = irq_q;

endmodule : tmc_tx_mib_counters

`default_nettype wire

// ===== sim/testbench.sv
// testbench: tx statistics counter bank, frame table then edge cases
`default_nettype none

module testbench
  import tmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic en; logic [1:0] msk; logic ok; logic [15:0] oct; logic vl; logic [4:0] col;
    logic [15:0] d_o; logic d_c;
  } tmc_tb_row_type;

  logic             clock, rstn, sw_reset, en, send, irq, irq_seen, er;
  logic [1:0]       mask;
  tmc_tx_event_type tx_evt, frame;
  tmc_reg_req_type  req;
  tmc_reg_rsp_type  rsp;
  logic [CNT_W-1:0] v, exp_o, exp_c;
  int               num_errors, cmp_count;

  // enable, mask, ok, octets, tag, collisions, octet delta, single delta
  localparam tmc_tb_row_type ROWS [7] = '{
    '{1'h1, 2'h0, 1'h1, 16'h003C, 1'h0, 5'h00, 16'h003C, 1'h0},
    '{1'h1, 2'h0, 1'h1, 16'h003C, 1'h1, 5'h01, 16'h0040, 1'h1},
    '{1'h1, 2'h0, 1'h0, 16'h0040, 1'h0, 5'h01, 16'h0000, 1'h0},
    '{1'h1, 2'h0, 1'h1, 16'h05EE, 1'h0, 5'h02, 16'h05EE, 1'h0},
    '{1'h0, 2'h0, 1'h1, 16'h0100, 1'h0, 5'h01, 16'h0000, 1'h0},
    '{1'h1, 2'h1, 1'h1, 16'h0100, 1'h1, 5'h01, 16'h0000, 1'h1},
    '{1'h1, 2'h2, 1'h1, 16'h0100, 1'h1, 5'h01, 16'h0104, 1'h0}};

  tmc_mac_tx_model mac_u (.clock(clock), .rstn(rstn), .send(send), .frame(frame),
    .tx_evt(tx_evt));
  tmc_tx_mib_counters dut_u (.clock(clock), .rstn(rstn), .sw_reset(sw_reset),
    .tx_evt(tx_evt), .stats_global_enable(en), .stats_counter_mask(mask),
    .reg_req(req), .reg_rsp(rsp), .stats_update_irq(irq));

  ////////////////////////////////////////
  task automatic check(string what, logic [CNT_W-1:0] exp, logic [CNT_W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one access: strobe for one edge, answer read while ack stands, then an idle
  // edge so back-to-back calls never touch req twice in one time step
  task automatic acc(logic w, logic [7:0] a, logic [3:0] be, logic [CNT_W-1:0] wd);
    req = '{rd: !w, wr: w, addr: a, be: be, wdata: wd};
    @(negedge clock);
    req = '0;
    check("ack", 32'h1, 32'(rsp.ack));
    v = rsp.rdata;
    er = rsp.err;
    @(negedge clock);
  endtask : acc

  task automatic rd_chk(logic [7:0] a, logic [CNT_W-1:0] exp);
    acc(1'h0, a, BE_DWORD, 32'h0);
    check("count", exp, v);
    check("err", 32'h0, 32'(er));
  endtask : rd_chk

  // one frame report, then watch long enough to catch the update pulse
  task automatic frame_go(logic ok, logic [15:0] oct, logic vl, logic [4:0] col);
    frame = '{done: 1'h0, ok: ok, octets: oct, vlan_inserted: vl, collisions: col};
    send = 1'h1;
    irq_seen = 1'h0;
    @(negedge clock);
    send = 1'h0;
    repeat (5) begin
      @(negedge clock);
      irq_seen = irq_seen | irq;
    end
  endtask : frame_go

  task automatic end_of_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////
  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end

  // watchdog: whole run needs about 150 cycles
  initial begin
    #(25 * 3000);
    num_errors++;
    end_of_test();
  end

  initial begin
    {rstn, sw_reset, en, send, mask, frame, req, exp_o, exp_c} = '0;
    repeat (3) @(negedge clock);
    rstn = 1'h1;
    rd_chk(OFS_TX_OCTET, CNT_RESET);
    rd_chk(OFS_SINGLE_COL, CNT_RESET);
    $display("reset test done");
    foreach (ROWS[i]) begin
      en = ROWS[i].en;
      mask = ROWS[i].msk;
      frame_go(ROWS[i].ok, ROWS[i].oct, ROWS[i].vl, ROWS[i].col);
      exp_o += 32'(ROWS[i].d_o);
      exp_c += 32'(ROWS[i].d_c);
      rd_chk(OFS_TX_OCTET, exp_o);
      rd_chk(OFS_SINGLE_COL, exp_c);
      check("irq", 32'h0, 32'(irq_seen));
      $display("row %0d done", i);
    end
    mask = 2'h0;
    acc(1'h1, OFS_TX_OCTET, BE_DWORD, 32'hFFFF_FFF0);
    frame_go(1'h1, 16'h0014, 1'h0, 5'h00);
    rd_chk(OFS_TX_OCTET, 32'h0000_0004);
    acc(1'h1, OFS_SINGLE_COL, BE_DWORD, 32'hFFFF_FFFF);
    frame_go(1'h1, 16'h0010, 1'h0, 5'h01);
    rd_chk(OFS_SINGLE_COL, 32'h0000_0000);
    $display("wrap test done");
    acc(1'h1, OFS_TX_OCTET, BE_DWORD, 32'hBFFF_FFF0);
    frame_go(1'h1, 16'h000C, 1'h1, 5'h00);
    rd_chk(OFS_TX_OCTET, CNT_THRESH);
    check("irq", 32'h1, 32'(irq_seen));
    acc(1'h1, OFS_SINGLE_COL, BE_DWORD, 32'hBFFF_FFFF);
    frame_go(1'h1, 16'h0040, 1'h0, 5'h01);
    check("irq", 32'h1, 32'(irq_seen));
    acc(1'h1, OFS_TX_OCTET, BE_DWORD, 32'hBFFF_FFF0);
    mask = 2'h1;
    frame_go(1'h1, 16'h0040, 1'h0, 5'h00);
    rd_chk(OFS_TX_OCTET, 32'hBFFF_FFF0);
    check("irq", 32'h0, 32'(irq_seen));
    $display("update mark test done");
    acc(1'h1, OFS_SINGLE_COL, 4'h3, 32'h1234_5678);
    check("err", 32'h1, 32'(er));
    rd_chk(OFS_SINGLE_COL, CNT_THRESH);
    acc(1'h0, 8'hF4, BE_DWORD, 32'h0);
    check("unmapped", 32'h1, 32'(er));
    check("unmapped data", RDATA_UNMAPPED, v);
    acc(1'h0, OFS_TX_OCTET, 4'hC, 32'h0);
    check("partial read err", 32'h1, 32'(er));
    check("partial read data", RDATA_UNMAPPED, v);
    sw_reset = 1'h1;
    @(negedge clock);
    sw_reset = 1'h0;
    rd_chk(OFS_SINGLE_COL, CNT_RESET);
    rd_chk(OFS_TX_OCTET, CNT_RESET);
    $display("access and soft reset test done");
    // hard reset in mid-run clears a freshly written counter
    acc(1'h1, OFS_TX_OCTET, BE_DWORD, 32'h1234_5678);
    rstn = 1'h0;
    @(negedge clock);
    rstn = 1'h1;
    rd_chk(OFS_TX_OCTET, CNT_RESET);
    rd_chk(OFS_SINGLE_COL, CNT_RESET);
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule : testbench

`default_nettype wire

// ===== sim/tmc_mac_tx_model.sv
// model: mac transmit path giving end-of-frame reports on request
`default_nettype none

module tmc_mac_tx_model
  import tmc_pkg::*;
(
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rstn,
  // request from the bench
  input  wire logic                      send,
  input  wire tmc_pkg::tmc_tx_event_type frame,
  // report toward the counter bank
  output tmc_pkg::tmc_tx_event_type      tx_evt
);
  logic [CNT_W-1:0] junk_q;

  // idle fields churn so a stale report never passes for a fresh one
  always @(negedge clock or negedge rstn) begin
    if (!rstn) begin
      junk_q <= 32'h0000_0000;
    end else begin
      junk_q <= junk_q + 32'h9E37_79B9;
    end
  end

  // done is high only while the bench holds send, one cycle each
  always_comb begin
    tx_evt = junk_q[$bits(tmc_tx_event_type)-1:0];
    tx_evt.done = 1'b0;
    if (send) begin
      tx_evt = frame;
      tx_evt.done = 1'b1;
    end
  end
endmodule : tmc_mac_tx_model

`default_nettype wire

// ===== sim/tmc_tx_mib_monitor.sv
// checker: port assertions for the tx statistics counter bank
`default_nettype none

module tmc_tx_mib_monitor
  import tmc_pkg::*;
#(
  parameter int                        NUM    = 2,
  parameter logic [tmc_pkg::CNT_W-1:0] THRESH = 32'hC000_0000
)(
  // clock and resets
  input wire logic                       clock,
  input wire logic                       rstn,
  input wire logic                       sw_reset,
  // watched ports
  input wire tmc_pkg::tmc_tx_event_type  tx_evt,
  input wire logic                       stats_global_enable,
  input wire logic [NUM-1:0]             stats_counter_mask,
  input wire tmc_pkg::tmc_reg_req_type   reg_req,
  input wire tmc_pkg::tmc_reg_rsp_type   reg_rsp,
  input wire logic                       stats_update_irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////
  // register window answers
  a_ack_follows: assert property ((reg_req.rd || reg_req.wr) |=> reg_rsp.ack)
    else $error("ack missing after access");
  a_no_spur_ack: assert property (!(reg_req.rd || reg_req.wr) |=> !reg_rsp.ack && !reg_rsp.err)
    else $error("ack or err without access");
  a_err_partial: assert property ((reg_req.rd || reg_req.wr) && reg_req.be != BE_DWORD
      |=> reg_rsp.err && reg_rsp.ack)
    else $error("partial access not refused");
  a_dword_ok: assert property ((reg_req.rd || reg_req.wr) && reg_req.be == BE_DWORD
      && (reg_req.addr == OFS_SINGLE_COL || reg_req.addr == OFS_TX_OCTET) |=> !reg_rsp.err)
    else $error("mapped dword access refused");
  a_unmapped_zero: assert property (reg_req.rd && reg_req.addr != OFS_SINGLE_COL
      && reg_req.addr != OFS_TX_OCTET |=> reg_rsp.err && reg_rsp.rdata == RDATA_UNMAPPED)
    else $error("unmapped read not zero with err");

  ////////////////////////////////////////
  // update pulse only from a counted frame
  // done is sampled two edges before the pulse shows; enable and mask one edge before
  a_irq_cause: assert property (stats_update_irq |-> $past(tx_evt.done && tx_evt.ok, 2))
    else $error("update pulse without frame");
  a_irq_enabled: assert property (stats_update_irq |-> $past(stats_global_enable, 1))
    else $error("update pulse while disabled");
  a_irq_unmasked: assert property (stats_update_irq |-> !(&$past(stats_counter_mask, 1)))
    else $error("update pulse with all masked");
  a_sw_quiet: assert property (sw_reset |=> !stats_update_irq)
    else $error("update pulse after soft reset");
endmodule : tmc_tx_mib_monitor

bind tmc_tx_mib_counters tmc_tx_mib_monitor #(.NUM(NUM), .THRESH(THRESH)) mon_u (
  .clock(clock), .rstn(rstn), .sw_reset(sw_reset), .tx_evt(tx_evt),
  .stats_global_enable(stats_global_enable), .stats_counter_mask(stats_counter_mask),
  .reg_req(reg_req), .reg_rsp(reg_rsp), .stats_update_irq(stats_update_irq)
);

`default_nettype wire
